// >>> hdl/lssw_pkg.sv
package lssw_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] LINE_STATUS_WORD_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] EVENT_STATUS_ADDR = 8'h11;
  localparam logic [ADDR_W-1:0] EVENT_MASK_ADDR = 8'h12;
  // arbitrary neutral revision value
  localparam logic [4:0] PART_REVISION_DEFAULT = 5'h15;
  localparam int REV_MSB = 15;
  localparam int REV_LSB = 11;
  localparam int CARRIER_BIT = 10;
  localparam int PRIOR_MSB = 9;
  localparam int PRIOR_LSB = 8;
  localparam int CUR_MSB = 7;
  localparam int CUR_LSB = 5;
  localparam int EVT_W = 2;
  localparam int EVT_CHANGE = 0;
  localparam int EVT_CARRIER = 1;
  localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
  localparam logic [EVT_W-1:0] EVT_ZERO = 2'h0;

  typedef enum logic [2:0] {
    LSSW_NOISE = 3'h0,
    LSSW_ACTIVE = 3'h1,
    LSSW_UNDEF = 3'h2,
    LSSW_SHORT_IDLE = 3'h3,
    LSSW_QUIET = 3'h4,
    LSSW_MASTER = 3'h5,
    LSSW_HALT = 3'h6,
    LSSW_LONG_IDLE = 3'h7
  } lssw_cond_t;

  typedef enum logic [1:0] {
    LSSW_PRIOR_QUIET = 2'h0,
    LSSW_PRIOR_MASTER = 2'h1,
    LSSW_PRIOR_HALT = 2'h2,
    LSSW_PRIOR_LONG_IDLE = 2'h3
  } lssw_prior_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } lssw_req_t;

  typedef struct packed {
    logic change;
    lssw_cond_t cond;
  } lssw_track_t;
endpackage

// >>> hdl/lssw_sync.sv
`timescale 1ns/1ns
module lssw_sync (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_async,
  output logic o_sync
);
  logic stage1;
  logic stage2;
  logic next_stage1;
  logic next_stage2;

  always_comb begin
    next_stage1 = i_async;
    next_stage2 = stage1;
  end

  // first stage feeds only the second
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign o_sync = stage2;
endmodule

// >>> hdl/lssw_top.sv
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ns
module lssw_top #(
  parameter logic [4:0] PART_REVISION = lssw_pkg::PART_REVISION_DEFAULT
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire lssw_pkg::lssw_req_t i_req,
  input wire lssw_pkg::lssw_track_t i_track,
  input wire logic i_carrier_present_input,
  output logic [lssw_pkg::DATA_W-1:0] o_rdata,
  output logic o_irq
);
  import lssw_pkg::*;

  logic rd_word;
  logic rd_event;
  logic rd_mask;
  logic wr_mask;
  logic carrier_sync;
  logic carrier_last;
  logic next_carrier_last;
  logic carrier_edge;
  logic cond_taken;
  lssw_cond_t current_link_condition;
  lssw_cond_t next_current;
  lssw_prior_t prior_link_condition;
  lssw_prior_t next_prior;
  logic prior_capture;
  lssw_prior_t prior_code;
  logic [REV_MSB-REV_LSB:0] part_revision_field;
  logic carrier_absent;
  logic [DATA_W-1:0] status_word;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] next_status;
  logic [EVT_W-1:0] evt_mask;
  logic [EVT_W-1:0] next_mask;
  logic irq;
  logic next_irq;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;

  // carrier pin comes from the receiver, outside this clock
  lssw_sync lssw_sync_inst (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_async(i_carrier_present_input),
    .o_sync(carrier_sync)
  );

  // register port decode; only the mask takes writes
  always_comb begin
    rd_word = 1'b0;
    rd_event = 1'b0;
    rd_mask = 1'b0;
    wr_mask = 1'b0;
    if (i_req.rd) begin
      case (i_req.addr)
        LINE_STATUS_WORD_ADDR: begin
          rd_word = 1'b1;
        end
        EVENT_STATUS_ADDR: begin
          rd_event = 1'b1;
        end
        EVENT_MASK_ADDR: begin
          rd_mask = 1'b1;
        end
        default: begin
          rd_word = 1'b0;
        end
      endcase
    end
    // writes to the status word fall through untouched
    if (i_req.wr && (i_req.addr == EVENT_MASK_ADDR)) begin
      wr_mask = 1'b1;
    end
  end

  // edge detector starts at the same level as the reset sync flops
  always_comb begin
    next_carrier_last = carrier_sync;
    carrier_edge = carrier_sync ^ carrier_last;
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      carrier_last <= 1'b0;
    end else begin
      carrier_last <= next_carrier_last;
    end
  end

  // a repeated report of the same condition is not a change
  always_comb begin
    cond_taken = i_track.change && (i_track.cond != current_link_condition);
    next_current = current_link_condition;
    if (cond_taken) begin
      next_current = i_track.cond;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      current_link_condition <= LSSW_NOISE;
    end else begin
      current_link_condition <= next_current;
    end
  end

  // only the four long-lived conditions are worth remembering
  always_comb begin
    prior_capture = 1'b0;
    prior_code = prior_link_condition;
    case (current_link_condition)
      LSSW_QUIET: begin
        prior_capture = 1'b1;
        prior_code = LSSW_PRIOR_QUIET;
      end
      LSSW_MASTER: begin
        prior_capture = 1'b1;
        prior_code = LSSW_PRIOR_MASTER;
      end
      LSSW_HALT: begin
        prior_capture = 1'b1;
        prior_code = LSSW_PRIOR_HALT;
      end
      LSSW_LONG_IDLE: begin
        prior_capture = 1'b1;
        prior_code = LSSW_PRIOR_LONG_IDLE;
      end
      default: begin
        prior_capture = 1'b0;
        prior_code = prior_link_condition;
      end
    endcase
    next_prior = prior_link_condition;
    if (cond_taken && prior_capture) begin
      next_prior = prior_code;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      prior_link_condition <= LSSW_PRIOR_QUIET;
    end else begin
      prior_link_condition <= next_prior;
    end
  end

  // pure wiring of live state, so reading it changes nothing
  always_comb begin
    part_revision_field = PART_REVISION;
    carrier_absent = ~carrier_sync;
    status_word = ZERO_WORD;
    status_word[REV_MSB:REV_LSB] = part_revision_field;
    status_word[CARRIER_BIT] = carrier_absent;
    status_word[PRIOR_MSB:PRIOR_LSB] = prior_link_condition;
    status_word[CUR_MSB:CUR_LSB] = current_link_condition;
  end

  always_comb begin
    evt_set = EVT_ZERO;
    evt_set[EVT_CHANGE] = cond_taken;
    evt_set[EVT_CARRIER] = carrier_edge;
  end

  // a new event beats a read-clear in the same cycle
  for (genvar b = 0; b < EVT_W; b++) begin : g_evt
    assign next_status[b] = evt_set[b] | (evt_status[b] & ~rd_event);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      evt_status <= EVT_ZERO;
    end else begin
      evt_status <= next_status;
    end
  end

  always_comb begin
    next_mask = evt_mask;
    if (wr_mask) begin
      next_mask = i_req.wdata[EVT_W-1:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      evt_mask <= EVT_ZERO;
    end else begin
      evt_mask <= next_mask;
    end
  end

  // irq follows the next status so it rises with the sticky bit
  always_comb begin
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  always_comb begin
    next_rdata = ZERO_WORD;
    if (rd_word) begin
      next_rdata = status_word;
    end else if (rd_event) begin
      next_rdata[EVT_W-1:0] = evt_status;
    end else if (rd_mask) begin
      next_rdata[EVT_W-1:0] = evt_mask;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rdata <= ZERO_WORD;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign o_rdata = rdata;
  assign o_irq = irq;
endmodule

// >>> sim/lssw_asserts.sv
`timescale 1ns/1ns
module lssw_asserts #(
  parameter logic [4:0] PART_REVISION = lssw_pkg::PART_REVISION_DEFAULT
) (
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire lssw_pkg::lssw_req_t i_req,
  input wire lssw_pkg::lssw_track_t i_track,
  input wire logic i_carrier_present_input,
  input wire logic [15:0] o_rdata,
  input wire logic o_irq
);
  import lssw_pkg::*;
  logic [2:0] m_cur;
  logic [1:0] m_pri;
  wire logic c = i_carrier_present_input;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // shadow of the tracker so read data can be tied to its cause
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      m_cur <= 3'h0;
      m_pri <= 2'h0;
    end else if (i_track.change && i_track.cond != m_cur) begin
      m_cur <= i_track.cond;
      if (m_cur[2]) m_pri <= m_cur[1:0];
    end
  end
  sequence s_rd; i_req.rd && i_req.addr == 8'h10; endsequence
  // pin must settle through the sync flops first
  sequence s_car; c == $past(c) && c == $past(c, 2) && c == $past(c, 3); endsequence
  property p_rev; s_rd |=> o_rdata[15:11] == PART_REVISION; endproperty
  a_rev: assert property (p_rev) else $error("revision field");
  property p_car; s_rd ##0 s_car |=> o_rdata[10] == !$past(c); endproperty
  a_car: assert property (p_car) else $error("carrier flag");
  property p_pri; s_rd |=> o_rdata[9:8] == $past(m_pri); endproperty
  a_pri: assert property (p_pri) else $error("prior field");
  property p_cur; s_rd |=> o_rdata[7:5] == $past(m_cur); endproperty
  a_cur: assert property (p_cur) else $error("current field");
  property p_low; s_rd |=> o_rdata[4:0] == 5'h00; endproperty
  a_low: assert property (p_low) else $error("low bits");
  property p_idle; !i_req.rd |=> o_rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("data without read");
  property p_unm; i_req.rd && i_req.addr > 8'h12 |=> o_rdata == 16'h0000; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_msk; i_req.rd && i_req.addr == 8'h12 |=> o_rdata[15:2] == 14'h0000; endproperty
  a_msk: assert property (p_msk) else $error("mask width");
endmodule

// >>> sim/lssw_top_tb_top.sv
`timescale 1ns/1ns
module lssw_top_tb_top;
  import lssw_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic car = 1'b0;
  logic irq;
  lssw_req_t req = '0;
  lssw_track_t trk = '0;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [2:0] cur = 3'h0;
  logic [1:0] pri = 2'h0;
  logic [2:0] seq_c [10] = '{3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7, 3'h7, 3'h0, 3'h4};
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  lssw_top lssw_top_inst (
    .i_clk_sys(clk),
    .i_reset(rst),
    .i_req(req),
    .i_track(trk),
    .i_carrier_present_input(car),
    .o_rdata(rdata),
    .o_irq(irq)
  );
  task chk(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk_irq(string n, logic e);
    comparisons++;
    if (irq !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", n, e, irq);
    end
  endtask
  task rd(logic [7:0] a);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  task wr(logic [7:0] a, logic [15:0] v);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask
  // expectation kept alongside, from the encodings alone
  task tk(logic [2:0] c);
    @(posedge clk);
    trk.change <= 1'b1;
    trk.cond <= lssw_cond_t'(c);
    @(posedge clk);
    trk.change <= 1'b0;
    if (c != cur) begin
      if (cur[2]) begin
        pri = cur[1:0];
      end
      cur = c;
    end
  endtask
  function logic [15:0] ew();
    return {PART_REVISION_DEFAULT, ~car, pri, cur, 5'h00};
  endfunction
  task tally_and_finish;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      failures++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(8'h10);
    chk("word", ew(), d);
    @(posedge clk);
    car <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h10);
    chk("carrier", ew(), d);
    wr(8'h12, 16'h0001);
    rd(8'h12);
    chk("mask", 16'h0001, d);
    chk_irq("irq carrier masked", 1'b0);
    rd(8'h11);
    chk("carrier event", 16'h0002, d);
    foreach (seq_c[i]) begin
      tk(seq_c[i]);
      rd(8'h10);
      chk("cond", ew(), d);
    end
    chk_irq("irq", 1'b1);
    rd(8'h11);
    chk("event", 16'h0001, d);
    repeat (2) @(negedge clk);
    chk_irq("irq cleared", 1'b0);
    wr(8'h12, 16'h0000);
    tk(3'h3);
    repeat (3) @(negedge clk);
    chk_irq("irq masked", 1'b0);
    rd(8'h11);
    chk("event", 16'h0001, d);
    wr(8'h10, 16'hFFFF);
    rd(8'h10);
    chk("ro", ew(), d);
    rd(8'h10);
    chk("again", ew(), d);
    rd(8'h30);
    chk("unmapped", 16'h0000, d);
    tally_and_finish;
  end
endmodule
bind lssw_top lssw_asserts #(.PART_REVISION(PART_REVISION)) lssw_asserts_inst (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(i_req), .i_track(i_track),
  .i_carrier_present_input(i_carrier_present_input), .o_rdata(o_rdata), .o_irq(o_irq));
